// [src/lpcg_pkg.sv]
// Constants and carrier types of the unit clock gating block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
// What this block does
// [RQ1] Enable bit one clocks unit, zero stops it
// [RQ2] Access to unclocked unit answers bus fault
// [RQ3] Gating bits reset to zero unless stated
// [RQ4] Bit 16 enables converter unit clock
// [RQ5] Sleep register rate field bits 9:8
// [RQ6] Stored rate never exceeds unit maximum
// [RQ7] Bit 6 hibernation enable, resets to one
// [RQ8] Bit 3 watchdog enable, resets to zero
// [RQ9] Reserved bits read zero, ignore writes
// [RQ10] Separate run, sleep, deep-sleep gating registers
// [RQ11] Sleep registers act only with auto select
// [RQ12] Deep-sleep register at 0x120, no rate
// [RQ13] Deep-sleep register resets to 0x00000040
// [RQ14] Software enables units before using them
// [RQ15] Sleep register at 0x110, resets 0x00000040
// [RQ16] Without auto select run register always applies
package lpcg_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_RUN_GATE   = 12'h100;
  localparam logic [11:0] OFS_SLEEP_GATE = 12'h110;
  localparam logic [11:0] OFS_DEEP_GATE  = 12'h120;
  localparam logic [11:0] OFS_RUN_CFG    = 12'h130;
  localparam logic [11:0] OFS_IRQ_STAT   = 12'h140;
  localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h144;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h148;

  // Field positions
  localparam int BIT_ADC         = 16;
  localparam int BIT_RATE_LO     = 8;
  localparam int BIT_HIBERNATION = 6;
  localparam int BIT_WATCHDOG    = 3;
  localparam int BIT_AUTO_SEL    = 0;

  // Reset values
  localparam logic [31:0] RST_GATE     = 32'h0000_0040;
  localparam logic [31:0] RST_RUN_CFG  = 32'h0000_0000;
  localparam logic [1:0]  RST_IRQ      = 2'h0;

  // Converter sample rate codes
  localparam logic [1:0] RATE_125K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  // Interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_CLAMP = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power state from the power-state controller, one-hot
  typedef enum logic [2:0] {
    PS_RUN   = 3'h1,
    PS_SLEEP = 3'h2,
    PS_DEEP  = 3'h4
  } lpcg_pstate_t;

  // One enable per gated unit
  typedef struct packed {
    logic adc;
    logic hibernation_gate;
    logic watchdog_gate;
  } lpcg_units_t;

  // Content of one gating register
  typedef struct packed {
    lpcg_units_t en;
    logic [1:0]  rate;
  } lpcg_gate_t;

endpackage : lpcg_pkg

// [src/lpcg_top.sv]
// Unit clock gating control: run, sleep and deep-sleep gating registers
// behind an AXI4-Lite slave. Assumes the gated units hold their own
// clock gate cells fed by unit_clk_en, and that the fabric reports each
// access aimed at a unit on unit_access.
module lpcg_top #(
  parameter logic [1:0] MAX_RATE = lpcg_pkg::RATE_1M
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // AXI4-Lite slave
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Power state and gated units
  input  wire lpcg_pkg::lpcg_pstate_t power_state,
  input  wire lpcg_pkg::lpcg_units_t  unit_access,
  output lpcg_pkg::lpcg_units_t       unit_bus_fault,
  output lpcg_pkg::lpcg_units_t       unit_clk_en,
  output logic [1:0]                  converter_sample_rate,
  output logic                        irq
);

  typedef struct packed {
    lpcg_pkg::lpcg_gate_t  run;
    lpcg_pkg::lpcg_gate_t  slp;
    lpcg_pkg::lpcg_gate_t  dsl;
    logic                  auto_sel;
    logic [1:0]            sts;
    logic [1:0]            ien;
    lpcg_pkg::lpcg_units_t clk_en;
    logic [1:0]            rate;
    logic                  aw_got;
    logic [11:0]           awaddr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } lpcg_state_t;

  lpcg_state_t st;
  lpcg_state_t next_st;

  // Gating register as seen on the bus; reserved bits read zero
  function automatic logic [31:0] gate_word(lpcg_pkg::lpcg_gate_t g,
                                            logic has_rate);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[lpcg_pkg::BIT_ADC] = g.en.adc; // RQ4
    w[lpcg_pkg::BIT_HIBERNATION] = g.en.hibernation_gate; // RQ7
    w[lpcg_pkg::BIT_WATCHDOG]    = g.en.watchdog_gate; // RQ8
    if (has_rate) begin
      w[lpcg_pkg::BIT_RATE_LO +: 2] = g.rate; // RQ5
    end
    return w; // RQ9
  endfunction

  // Byte-lane merge of a write into the old word
  function automatic logic [31:0] lane_merge(logic [31:0] old,
                                             logic [31:0] wd,
                                             logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Word back to register fields; only writable bits are kept
  function automatic lpcg_pkg::lpcg_gate_t gate_unpack(logic [31:0] w,
                                                        logic has_rate);
    lpcg_pkg::lpcg_gate_t g;
    g.en.adc = w[lpcg_pkg::BIT_ADC];
    g.en.hibernation_gate = w[lpcg_pkg::BIT_HIBERNATION];
    g.en.watchdog_gate    = w[lpcg_pkg::BIT_WATCHDOG];
    g.rate   = 2'h0;
    if (has_rate) begin
      g.rate = w[lpcg_pkg::BIT_RATE_LO +: 2];
    end
    return g;
  endfunction

  // Faster codes are cut back to the unit's ceiling
  function automatic logic [1:0] rate_limit(logic [1:0] r);
    return (r > MAX_RATE) ? MAX_RATE : r; // RQ6
  endfunction

  // Read mux, shared by the read channel and the write lane merge
  function automatic logic [31:0] reg_read(lpcg_state_t s,
                                           logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      lpcg_pkg::OFS_RUN_GATE:   w = gate_word(s.run, 1'b1);
      lpcg_pkg::OFS_SLEEP_GATE: w = gate_word(s.slp, 1'b1);
      lpcg_pkg::OFS_DEEP_GATE:  w = gate_word(s.dsl, 1'b0); // RQ12
      lpcg_pkg::OFS_RUN_CFG:    w[lpcg_pkg::BIT_AUTO_SEL] = s.auto_sel;
      lpcg_pkg::OFS_IRQ_STAT:   w[1:0] = s.sts;
      lpcg_pkg::OFS_IRQ_ENABLE: w[1:0] = s.ien;
      default:                  w = 32'h0000_0000; // Clear reg is write-only
    endcase
    return w;
  endfunction

  // Every decoded address; anything else answers a slave error so that
  // a stray pointer in software shows up instead of reading silent zeros
  function automatic logic mapped(logic [11:0] a);
    return a == lpcg_pkg::OFS_RUN_GATE   || a == lpcg_pkg::OFS_SLEEP_GATE ||
           a == lpcg_pkg::OFS_DEEP_GATE  || a == lpcg_pkg::OFS_RUN_CFG    ||
           a == lpcg_pkg::OFS_IRQ_STAT   || a == lpcg_pkg::OFS_IRQ_CLEAR  ||
           a == lpcg_pkg::OFS_IRQ_ENABLE;
  endfunction

  lpcg_pkg::lpcg_gate_t sel_gate;
  lpcg_pkg::lpcg_units_t fault;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic [31:0] wword;
  logic [1:0] wrate;
  logic [1:0] ev;

  // Handshakes: address and data are taken in either order
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready  = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = st.aw_got && st.w_got && !st.bvalid;

  // Sleep registers only count under auto select, else run applies
  always_comb begin
    sel_gate = st.run; // RQ16
    if (st.auto_sel) begin // RQ11
      unique case (power_state)
        lpcg_pkg::PS_SLEEP: sel_gate = st.slp; // RQ10
        lpcg_pkg::PS_DEEP: begin
          sel_gate      = st.dsl; // RQ10
          sel_gate.rate = st.run.rate; // Deep sleep has no rate field
        end
        default: sel_gate = st.run;
      endcase
    end
  end

  // Fault uses the registered enables, so it matches what units see
  assign fault = unit_access & ~st.clk_en; // RQ2
  assign unit_bus_fault = fault;

  always_comb begin
    next_st = st;
    wword   = 32'h0000_0000;
    wrate   = 2'h0;
    ev      = 2'h0;

    // Enables re-timed through a flop: one clean edge per change,
    // which the unit's gate cell needs to stay glitch-free
    next_st.clk_en = sel_gate.en; // RQ1 RQ16
    next_st.rate   = sel_gate.rate;
    ev[lpcg_pkg::IRQ_FAULT] = |fault;

    if (aw_hs) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end

    // Register write once both halves are held
    if (do_wr) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = mapped(st.awaddr) ? lpcg_pkg::RESP_OKAY
                                         : lpcg_pkg::RESP_SLVERR;
      // Merge against the read view, so reserved bits stay zero
      wword = lane_merge(reg_read(st, st.awaddr), st.wdata, st.wstrb);
      wrate = wword[lpcg_pkg::BIT_RATE_LO +: 2];
      unique case (st.awaddr)
        lpcg_pkg::OFS_RUN_GATE: begin
          next_st.run      = gate_unpack(wword, 1'b1); // RQ9
          next_st.run.rate = rate_limit(wrate); // RQ6
          ev[lpcg_pkg::IRQ_CLAMP] = wrate > MAX_RATE;
        end
        lpcg_pkg::OFS_SLEEP_GATE: begin
          next_st.slp      = gate_unpack(wword, 1'b1); // RQ5
          next_st.slp.rate = rate_limit(wrate); // RQ6
          ev[lpcg_pkg::IRQ_CLAMP] = wrate > MAX_RATE;
        end
        lpcg_pkg::OFS_DEEP_GATE:
          next_st.dsl = gate_unpack(wword, 1'b0); // RQ12
        lpcg_pkg::OFS_RUN_CFG:
          next_st.auto_sel = wword[lpcg_pkg::BIT_AUTO_SEL];
        lpcg_pkg::OFS_IRQ_CLEAR:
          next_st.sts = st.sts & ~wword[1:0];
        lpcg_pkg::OFS_IRQ_ENABLE:
          next_st.ien = wword[1:0];
        default: next_st.run = st.run; // Unmapped or read-only
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // New events set after the clear, so a coincident event survives
    next_st.sts = next_st.sts | ev;

    // Read answer registered one cycle after the address is taken
    if (ar_hs) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = reg_read(st, s_axi_araddr);
      next_st.rresp  = mapped(s_axi_araddr) ? lpcg_pkg::RESP_OKAY
                                            : lpcg_pkg::RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.run      <= gate_unpack(lpcg_pkg::RST_GATE, 1'b1); // RQ3 RQ7
      st.slp      <= gate_unpack(lpcg_pkg::RST_GATE, 1'b1); // RQ15
      st.dsl      <= gate_unpack(lpcg_pkg::RST_GATE, 1'b0); // RQ13
      st.auto_sel <= lpcg_pkg::RST_RUN_CFG[lpcg_pkg::BIT_AUTO_SEL];
      st.sts      <= lpcg_pkg::RST_IRQ;
      st.ien      <= lpcg_pkg::RST_IRQ;
      // Enables start from the same reset word as the registers, so
      // the units see no change at the first edge after release
      st.clk_en.adc <= lpcg_pkg::RST_GATE[lpcg_pkg::BIT_ADC]; // RQ3
      st.clk_en.hibernation_gate <=
        lpcg_pkg::RST_GATE[lpcg_pkg::BIT_HIBERNATION]; // RQ7
      st.clk_en.watchdog_gate <=
        lpcg_pkg::RST_GATE[lpcg_pkg::BIT_WATCHDOG]; // RQ8
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign s_axi_bvalid          = st.bvalid;
  assign s_axi_bresp           = st.bresp;
  assign s_axi_rvalid          = st.rvalid;
  assign s_axi_rdata           = st.rdata;
  assign s_axi_rresp           = st.rresp;
  assign unit_clk_en           = st.clk_en;
  assign converter_sample_rate = st.rate;
  assign irq                   = |(st.sts & st.ien);

endmodule // lpcg_top

// [verif/lpcg_properties.sv]
// Checker of the unit clock gating block, bound into lpcg_top.
// Assumes one clock domain and the top ports alone.
module lpcg_chk #(
  parameter logic [1:0] MAX_RATE = 2'h3
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire lpcg_pkg::lpcg_units_t unit_access,
  input wire lpcg_pkg::lpcg_units_t unit_bus_fault,
  input wire lpcg_pkg::lpcg_units_t unit_clk_en,
  input wire logic [1:0]            converter_sample_rate,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Both write halves taken at one edge
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_fault; unit_bus_fault == (unit_access & ~unit_clk_en);
  endproperty
  property p_rst_en; $rose(rst_n) |-> unit_clk_en == 3'h2; endproperty
  property p_rst_rate;
    $rose(rst_n) |-> converter_sample_rate == 2'h0 && !irq;
  endproperty
  property p_rate_max; converter_sample_rate <= MAX_RATE; endproperty
  property p_wr_ans; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
  property p_b_hold; s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  // A pending response blocks new requests on its channel
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_fault: assert property (p_fault)
    else $error("bus fault does not match gated access");
  a_rst_en: assert property (p_rst_en)
    else $error("unit enables wrong after reset");
  a_rst_rate: assert property (p_rst_rate)
    else $error("rate or irq wrong after reset");
  a_rate_max: assert property (p_rate_max)
    else $error("sample rate above maximum");
  a_wr_ans: assert property (p_wr_ans)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read response late");
  a_w_refuse: assert property (p_w_refuse)
    else $error("write taken while response pending");
  a_r_refuse: assert property (p_r_refuse)
    else $error("read taken while data pending");
endmodule // lpcg_chk

bind lpcg_top lpcg_chk #(.MAX_RATE(MAX_RATE)) u_chk (.*);

// [verif/tb.sv]
// Self-checking bench of lpcg_top over AXI4-Lite.
// Assumes the checker file is compiled alongside.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] a; logic [31:0] w; logic [31:0] x; logic [1:0] r;
  } lpcg_row_t;
  // Faster codes are stored as MR, so the clamp path gets exercised
  localparam logic [1:0] MR = 2'h2;
  localparam logic [31:0] SLP = 32'h0001_0048 | {22'h0, MR, 8'h00};
  logic clk = 1'h0, rst_n = 1'h0, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, converter_sample_rate, r;
  lpcg_pkg::lpcg_pstate_t power_state = lpcg_pkg::PS_RUN;
  lpcg_pkg::lpcg_units_t unit_access = 3'h0, unit_bus_fault, unit_clk_en;
  int err_count = 0, n_compared = 0, cycles = 0;
  lpcg_row_t rows [6] = '{
    '{12'h110, 32'hFFFF_FFFF, SLP, 2'h0},
    '{12'h120, 32'hFFFF_FFFF, 32'h0001_0048, 2'h0},
    '{12'h120, 32'h0000_0008, 32'h0000_0008, 2'h0},
    '{12'h1F0, 32'hFFFF_FFFF, 32'h0, lpcg_pkg::RESP_SLVERR},
    '{12'h144, 32'h0, 32'h0, 2'h0},
    '{12'h148, 32'h1, 32'h1, 2'h0}};
  lpcg_top #(.MAX_RATE(MR)) dut (.*);
  initial forever #5 clk = ~clk;
  task automatic give_verdict;
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // Bready rises only once both valids have dropped, in the same cycle as bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    logic ta, tw, g;
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    g = 1'h0;
    while (!g) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      g = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      s_axi_bready <= !g && !s_axi_awvalid && !s_axi_wvalid;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic [1:0] xr);
    logic ta, g;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    g = 1'h0;
    while (!g) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      g = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      s_axi_rready <= !g && !s_axi_arvalid;
    end
    `CHK(d, x)
    `CHK(r, xr)
  endtask
  // Gating follows its register one cycle later; allow margin
  task automatic gate(input logic [2:0] en, input logic [1:0] rt);
    repeat (3) @(posedge clk);
    #1;
    `CHK(unit_clk_en, en)
    `CHK(converter_sample_rate, rt)
    @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    gate(3'h2, 2'h0);
    for (int i = 0; i < 3; i++) begin
      rd(12'h100 + 12'(i * 16), 32'h40, 2'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      `CHK(r, rows[i].r)
      rd(rows[i].a, rows[i].x, rows[i].r);
    end
    wr(12'h100, 32'h0001_0248);
    gate(3'h7, 2'h2);
    // Units are enabled before use, so these accesses must not fault
    unit_access <= 3'h7;
    #1;
    `CHK(unit_bus_fault, 3'h0)
    @(posedge clk);
    unit_access <= 3'h0;
    // Run rate left at 1 so deep sleep shows it is borrowed from run
    wr(12'h100, 32'h0000_0100);
    gate(3'h0, 2'h1);
    unit_access <= 3'h5;
    #1;
    `CHK(unit_bus_fault, 3'h5)
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, 1'h1)
    @(posedge clk);
    unit_access <= 3'h0;
    wr(12'h144, 32'h1);
    @(posedge clk);
    #1;
    `CHK(irq, 1'h0)
    @(posedge clk);
    rd(12'h140, 32'h2, 2'h0);
    wr(12'h130, 32'h1);
    power_state <= lpcg_pkg::PS_SLEEP;
    gate(3'h7, MR);
    power_state <= lpcg_pkg::PS_DEEP;
    gate(3'h1, 2'h1);
    power_state <= lpcg_pkg::PS_RUN;
    gate(3'h0, 2'h1);
    // Partial strobe: only the rate lane is written, the rest is kept
    s_axi_wstrb <= 4'h2;
    wr(12'h110, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(12'h110, 32'h0001_0048, 2'h0);
    // Enabled clamp status drives the interrupt
    wr(12'h148, 32'h3);
    #1;
    `CHK(irq, 1'h1)
    @(posedge clk);
    // Mid-run reset puts every written register back to reset values
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    gate(3'h2, 2'h0);
    for (int i = 0; i < 3; i++) begin
      rd(12'h100 + 12'(i * 16), 32'h40, 2'h0);
    end
    rd(12'h130, 32'h0, 2'h0);
    `CHK(irq, 1'h0)
    give_verdict();
  end
endmodule // tb
